/* File: core/dtc_pkg.sv */
// Package for the dual 8-bit timer pair: register indices, field layouts, reset values.
// Assumes an APB master with 32-bit data; byte address is four times the register index.
`default_nettype none
package dtc_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned IDX_W  = 14;

    // Register indices (byte address = index * 4)
    localparam logic [IDX_W-1:0] IDX_CHAN0_COMPARE     = 14'h0026;
    localparam logic [IDX_W-1:0] IDX_CHAN1_COMPARE     = 14'h0027;
    localparam logic [IDX_W-1:0] IDX_CHAN0_PULSE_WIDTH = 14'h0028;
    localparam logic [IDX_W-1:0] IDX_CHAN1_PULSE_WIDTH = 14'h0029;
    localparam logic [IDX_W-1:0] IDX_CHAN0_MODE_CONFIG = 14'h002a;
    localparam logic [IDX_W-1:0] IDX_CHAN1_MODE_CONFIG = 14'h002b;
    localparam logic [IDX_W-1:0] IDX_PAIR_SHARED_CTRL  = 14'h002c;
    localparam logic [IDX_W-1:0] IDX_CHAN0_COUNT       = 14'h0030;
    localparam logic [IDX_W-1:0] IDX_CHAN1_COUNT       = 14'h0031;
    localparam logic [IDX_W-1:0] IDX_CLOCK_GATE0       = 14'h0f74;

    // Reset values
    localparam logic [7:0] RST_COMPARE     = 8'hff;
    localparam logic [7:0] RST_PULSE_WIDTH = 8'hff;
    localparam logic [7:0] RST_MODE_CONFIG = 8'hc0;
    localparam logic [3:0] RST_SHARED_CTRL = 4'h0;
    localparam logic [7:0] RST_CLOCK_GATE  = 8'h00;

    // Field positions and widths
    localparam int unsigned GATE_EN_BIT   = 4;
    localparam int unsigned CTRL_W        = 4;
    localparam int unsigned PRESCALE_W    = 11;
    localparam int unsigned LF_DIV_W      = 4;

    // Operating modes
    localparam logic [1:0] MODE_TIMER_A = 2'h0;
    localparam logic [1:0] MODE_TIMER_B = 2'h1;
    localparam logic [1:0] MODE_PWM     = 2'h2;
    localparam logic [1:0] MODE_PPG     = 2'h3;

    // Clock select codes usable from the low-frequency clock
    localparam logic [2:0] CKSEL_LF16 = 3'h0;
    localparam logic [2:0] CKSEL_LF8  = 3'h1;
    localparam logic [2:0] CKSEL_LF4  = 3'h7;
    localparam logic [3:0] LF16_MASK  = 4'hf;
    localparam logic [3:0] LF8_MASK   = 4'h7;
    localparam logic [3:0] LF4_MASK   = 4'h3;

    // Gear-clock prescale masks per clock-select code: /2^11 /2^10 /2^8 /2^6 /2^4 /2^2 /2 /1
    localparam logic [10:0] GEAR_MASK [8] = '{11'h7ff, 11'h3ff, 11'h0ff, 11'h03f,
                                              11'h00f, 11'h003, 11'h001, 11'h000};

    // Mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       output_flop_init;
        logic       double_buffer_enable;
        logic [2:0] clock_select;
        logic       external_source_select;
        logic [1:0] operating_mode;
    } dtc_mode_s;

    // Shared control layout, bit 3 down to bit 0
    typedef struct packed {
        logic output_and_select;
        logic cascade;
        logic chan1_run;
        logic chan0_run;
    } dtc_ctrl_s;
endpackage
`default_nettype wire

/* File: core/dtc_timer_pair.sv */
// Dual 8-bit timer/counter pair with 16-bit cascade, APB register slave and output pins.
// Assumes pins and the sampled low-frequency clock are synchronous to sys_clk; APB zero-wait slave.
//
// The APB register port is this design's own decision.
`default_nettype none
module dtc_timer_pair #(
    parameter int unsigned CNT_W = 8
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rstn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [dtc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        low_freq_clock,
    input  wire logic                        low_freq_osc_ok,
    input  wire logic                        low_power_mode,
    input  wire logic                        stop_mode_entry,
    input  wire logic                        chan0_count_input_pin,
    input  wire logic                        chan1_count_input_pin,
    output logic                             chan0_match_irq,
    output logic                             chan1_match_irq,
    output logic                             chan0_pwm_pin,
    output logic                             chan0_pulse_gen_pin,
    output logic                             chan1_pwm_pin,
    output logic                             chan1_pulse_gen_pin
);
    dtc_pkg::dtc_mode_s                  mode_reg [2];
    dtc_pkg::dtc_ctrl_s                  ctrl_reg;
    logic [7:0]                          gate_reg;
    logic [CNT_W-1:0]                    cmp_buf_reg [2];
    logic [CNT_W-1:0]                    cmp_act_reg [2];
    logic [CNT_W-1:0]                    pw_reg [2];
    logic [CNT_W-1:0]                    cnt_reg [2];
    logic [dtc_pkg::PRESCALE_W-1:0]      pre_reg;
    logic [dtc_pkg::LF_DIV_W-1:0]        lf_div_reg;
    logic                                lf_prev_reg;
    logic [1:0]                          pin_prev_reg;
    logic [1:0]                          out_ff_reg;
    logic [31:0]                         prdata_reg;
    logic                                pready_reg;
    logic                                pslverr_reg;
    logic [1:0]                          irq_reg;
    logic [3:0]                          pin_reg;

    logic                                gate_on;
    logic                                lf_rise;
    logic [1:0]                          pin_fall;
    logic [1:0]                          run_eff;
    logic [1:0]                          tick;
    logic [1:0]                          hit;
    logic [1:0]                          pw_hit;
    logic                                hit16;
    logic [2*CNT_W-1:0]                  cnt16;
    logic [2*CNT_W-1:0]                  cmp16;
    logic                                setup_ph;
    logic                                wr_en;
    logic [dtc_pkg::IDX_W-1:0]           idx;
    logic                                mapped;
    logic [31:0]                         rd_mux;
    logic [1:0]                          ch_out;
    dtc_pkg::dtc_mode_s                  src_cfg [2];

    // Picks one channel's count tick from its source configuration
    function automatic logic src_tick(input dtc_pkg::dtc_mode_s cfg,
                                      input logic lp,
                                      input logic osc_ok,
                                      input logic [dtc_pkg::PRESCALE_W-1:0] pre,
                                      input logic [dtc_pkg::LF_DIV_W-1:0] lfd,
                                      input logic lfr,
                                      input logic pfall);
        logic t;
        t = 1'b0;
        if (cfg.external_source_select) begin
            t = pfall;
        end else if (lp) begin
            // Low-frequency codes only; others give no clock
            if (cfg.clock_select == dtc_pkg::CKSEL_LF16) begin
                t = lfr && ((lfd & dtc_pkg::LF16_MASK) == dtc_pkg::LF16_MASK);
            end else if (cfg.clock_select == dtc_pkg::CKSEL_LF8) begin
                t = lfr && ((lfd & dtc_pkg::LF8_MASK) == dtc_pkg::LF8_MASK);
            end else if (cfg.clock_select == dtc_pkg::CKSEL_LF4) begin
                t = lfr && ((lfd & dtc_pkg::LF4_MASK) == dtc_pkg::LF4_MASK);
            end
            t = t && osc_ok;
        end else begin
            t = (pre & dtc_pkg::GEAR_MASK[cfg.clock_select]) ==
                dtc_pkg::GEAR_MASK[cfg.clock_select];
        end
        return t;
    endfunction

    function automatic logic is_timer_mode(input dtc_pkg::dtc_mode_s cfg);
        return (cfg.operating_mode == dtc_pkg::MODE_TIMER_A) ||
               (cfg.operating_mode == dtc_pkg::MODE_TIMER_B);
    endfunction

    always_comb begin
        gate_on   = gate_reg[dtc_pkg::GATE_EN_BIT];
        lf_rise   = low_freq_clock && !lf_prev_reg;
        pin_fall  = pin_prev_reg & ~{chan1_count_input_pin, chan0_count_input_pin};
        run_eff[1] = ctrl_reg.chan1_run;
        run_eff[0] = ctrl_reg.cascade ? ctrl_reg.chan1_run : ctrl_reg.chan0_run;
        src_cfg[1] = mode_reg[1];
        src_cfg[0] = ctrl_reg.cascade ? mode_reg[1] : mode_reg[0];
        for (int i = 0; i < 2; i++) begin
            tick[i] = gate_on && run_eff[i] &&
                      src_tick(src_cfg[i], low_power_mode, low_freq_osc_ok, pre_reg,
                               lf_div_reg, lf_rise, pin_fall[ctrl_reg.cascade ? 1 : i]);
            hit[i]    = tick[i] && (cnt_reg[i] == cmp_act_reg[i]);
            pw_hit[i] = tick[i] && (cnt_reg[i] == pw_reg[i]);
        end
        cnt16 = {cnt_reg[1], cnt_reg[0]};
        cmp16 = {cmp_act_reg[1], cmp_act_reg[0]};
        hit16 = tick[1] && (cnt16 == cmp16);
        for (int i = 0; i < 2; i++) begin
            ch_out[i] = is_timer_mode(mode_reg[i]) ? 1'b1 : out_ff_reg[i];
        end
    end

    // APB decode: no wait cycle; read data is captured in the setup cycle so it leaves a flip-flop
    always_comb begin
        setup_ph = psel && !penable;
        wr_en    = psel && penable && pwrite && pready_reg && !pslverr_reg;
        idx      = paddr[dtc_pkg::ADDR_W-1:2];
        mapped   = 1'b1;
        rd_mux   = 32'h0000_0000;
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (idx == dtc_pkg::IDX_CHAN0_COMPARE) begin
            rd_mux[CNT_W-1:0] = cmp_buf_reg[0];
        end else if (idx == dtc_pkg::IDX_CHAN1_COMPARE) begin
            rd_mux[CNT_W-1:0] = cmp_buf_reg[1];
        end else if (idx == dtc_pkg::IDX_CHAN0_PULSE_WIDTH) begin
            rd_mux[CNT_W-1:0] = pw_reg[0];
        end else if (idx == dtc_pkg::IDX_CHAN1_PULSE_WIDTH) begin
            rd_mux[CNT_W-1:0] = pw_reg[1];
        end else if (idx == dtc_pkg::IDX_CHAN0_MODE_CONFIG) begin
            rd_mux[7:0] = mode_reg[0];
        end else if (idx == dtc_pkg::IDX_CHAN1_MODE_CONFIG) begin
            rd_mux[7:0] = mode_reg[1];
        end else if (idx == dtc_pkg::IDX_PAIR_SHARED_CTRL) begin
            rd_mux[dtc_pkg::CTRL_W-1:0] = ctrl_reg;
        end else if (idx == dtc_pkg::IDX_CHAN0_COUNT) begin
            rd_mux[CNT_W-1:0] = cnt_reg[0];
        end else if (idx == dtc_pkg::IDX_CHAN1_COUNT) begin
            rd_mux[CNT_W-1:0] = cnt_reg[1];
        end else if (idx == dtc_pkg::IDX_CLOCK_GATE0) begin
            rd_mux[7:0] = gate_reg;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup_ph;
            pslverr_reg <= setup_ph && !mapped;
            if (setup_ph) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // Clock gate register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gate_reg <= dtc_pkg::RST_CLOCK_GATE;
        end else if (wr_en && idx == dtc_pkg::IDX_CLOCK_GATE0) begin
            gate_reg <= pwdata[7:0];
        end
    end

    // Shared control: STOP entry wins over a write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= dtc_pkg::RST_SHARED_CTRL;
        end else if (stop_mode_entry) begin
            ctrl_reg.chan0_run <= 1'b0;
            ctrl_reg.chan1_run <= 1'b0;
        end else if (wr_en && idx == dtc_pkg::IDX_PAIR_SHARED_CTRL) begin
            ctrl_reg.chan0_run <= pwdata[0];
            ctrl_reg.chan1_run <= pwdata[1];
            // Current run state decides, so a starting write still lands
            if (!ctrl_reg.chan0_run && !ctrl_reg.chan1_run) begin
                ctrl_reg.cascade           <= pwdata[2];
                ctrl_reg.output_and_select <= pwdata[3];
            end
        end
    end

    // Mode registers locked while their channel runs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_reg[0] <= dtc_pkg::RST_MODE_CONFIG;
            mode_reg[1] <= dtc_pkg::RST_MODE_CONFIG;
        end else if (wr_en) begin
            if (idx == dtc_pkg::IDX_CHAN0_MODE_CONFIG && !run_eff[0]) begin
                mode_reg[0] <= pwdata[7:0];
            end
            if (idx == dtc_pkg::IDX_CHAN1_MODE_CONFIG && !run_eff[1]) begin
                mode_reg[1] <= pwdata[7:0];
            end
        end
    end

    // Pulse width registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pw_reg[0] <= dtc_pkg::RST_PULSE_WIDTH;
            pw_reg[1] <= dtc_pkg::RST_PULSE_WIDTH;
        end else if (wr_en) begin
            if (idx == dtc_pkg::IDX_CHAN0_PULSE_WIDTH) begin
                pw_reg[0] <= pwdata[CNT_W-1:0];
            end
            if (idx == dtc_pkg::IDX_CHAN1_PULSE_WIDTH) begin
                pw_reg[1] <= pwdata[CNT_W-1:0];
            end
        end
    end

    // Compare: buffer holds the last write, active copy is matched against
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_buf_reg[0] <= dtc_pkg::RST_COMPARE;
            cmp_buf_reg[1] <= dtc_pkg::RST_COMPARE;
            cmp_act_reg[0] <= dtc_pkg::RST_COMPARE;
            cmp_act_reg[1] <= dtc_pkg::RST_COMPARE;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((ctrl_reg.cascade ? hit16 : hit[i]) && src_cfg[i].double_buffer_enable) begin
                    cmp_act_reg[i] <= cmp_buf_reg[i];
                end
                if (wr_en && idx == (i == 0 ? dtc_pkg::IDX_CHAN0_COMPARE : dtc_pkg::IDX_CHAN1_COMPARE)) begin
                    cmp_buf_reg[i] <= pwdata[CNT_W-1:0];
                    if (!run_eff[i] || !src_cfg[i].double_buffer_enable) begin
                        cmp_act_reg[i] <= pwdata[CNT_W-1:0];
                    end
                end
            end
        end
    end

    // Prescaler and low-frequency divider, both halted by the clock gate
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_reg      <= '0;
            lf_div_reg   <= '0;
            lf_prev_reg  <= 1'b0;
            pin_prev_reg <= 2'h0;
        end else begin
            lf_prev_reg  <= low_freq_clock;
            pin_prev_reg <= {chan1_count_input_pin, chan0_count_input_pin};
            if (gate_on) begin
                pre_reg <= pre_reg + 1'b1;
                if (lf_rise) begin
                    lf_div_reg <= lf_div_reg + 1'b1;
                end
            end
        end
    end

    // Up counters, 8-bit each or one 16-bit pair
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg[0] <= '0;
            cnt_reg[1] <= '0;
        end else if (ctrl_reg.cascade) begin
            if (!run_eff[1]) begin
                cnt_reg[0] <= '0;
                cnt_reg[1] <= '0;
            end else if (hit16) begin
                cnt_reg[0] <= '0;
                cnt_reg[1] <= '0;
            end else if (tick[1]) begin
                {cnt_reg[1], cnt_reg[0]} <= cnt16 + 1'b1;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!run_eff[i]) begin
                    cnt_reg[i] <= '0;
                end else if (hit[i]) begin
                    cnt_reg[i] <= '0;
                end else if (tick[i]) begin
                    cnt_reg[i] <= cnt_reg[i] + 1'b1;
                end
            end
        end
    end

    // Output flops for PWM/PPG; idle value is the programmed init level
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            out_ff_reg <= 2'h3;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!run_eff[i] || hit[i]) begin
                    out_ff_reg[i] <= mode_reg[i].output_flop_init;
                end else if (pw_hit[i]) begin
                    out_ff_reg[i] <= !mode_reg[i].output_flop_init;
                end
            end
        end
    end

    // Match requests, one-cycle pulses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_reg <= 2'h0;
        end else begin
            irq_reg[0] <= !ctrl_reg.cascade && hit[0];
            irq_reg[1] <= ctrl_reg.cascade ? hit16 : hit[1];
        end
    end

    // Pins: channel 0 idles high when ANDed or cascaded
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_reg <= 4'hf;
        end else begin
            if (ctrl_reg.output_and_select || ctrl_reg.cascade) begin
                pin_reg[1:0] <= 2'h3;
            end else begin
                pin_reg[1:0] <= {2{ch_out[0]}};
            end
            if (ctrl_reg.output_and_select) begin
                pin_reg[3:2] <= {2{ch_out[0] & ch_out[1]}};
            end else begin
                pin_reg[3:2] <= {2{ch_out[1]}};
            end
        end
    end

    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign chan0_match_irq     = irq_reg[0];
    assign chan1_match_irq     = irq_reg[1];
    assign chan0_pwm_pin       = pin_reg[0];
    assign chan0_pulse_gen_pin = pin_reg[1];
    assign chan1_pwm_pin       = pin_reg[2];
    assign chan1_pulse_gen_pin = pin_reg[3];
endmodule
`default_nettype wire

/* File: tb/dtc_timer_pair_monitor.sv */
// Checker for the timer pair: APB answer timing, run state and quiet outputs.
// Assumes binding to dtc_timer_pair; run, AND and gate state mirrored from APB writes.
`default_nettype none
module dtc_timer_pair_monitor (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        stop_mode_entry,
    input wire logic        chan0_match_irq,
    input wire logic        chan1_match_irq,
    input wire logic        chan0_pwm_pin,
    input wire logic        chan0_pulse_gen_pin
);
    logic [1:0] runs_q;
    logic       and_q;
    logic       gate_q;
    logic       wr_q;
    assign wr_q = psel && penable && pready && pwrite;
    // Stop entry wins over a control write in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            runs_q <= 2'h0;
            and_q  <= 1'b0;
        end else if (stop_mode_entry) begin
            runs_q <= 2'h0;
        end else if (wr_q && paddr == 16'h00b0) begin
            runs_q <= pwdata[1:0];
            if (runs_q == 2'h0)
                and_q <= pwdata[3];
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            gate_q <= 1'b0;
        else if (wr_q && paddr == 16'h3dd0)
            gate_q <= pwdata[4];
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer in the cycle after setup");
    a_unmapped_error: assert property (pready && paddr == 16'h0004 |-> pslverr)
        else $error("unmapped access without slave error");
    a_ctrl_read_back: assert property (pready && !pwrite && paddr == 16'h00b0 |-> prdata[31:4] == 28'h0 && prdata[1:0] == runs_q)
        else $error("control read back wrong");
    a_gate_off_quiet: assert property (!gate_q |-> !chan0_match_irq && !chan1_match_irq)
        else $error("match request with clock gated off");
    a_stopped_count_zero: assert property (pready && !pwrite && paddr == 16'h00c0 && runs_q == 2'h0 |-> prdata == 32'h0)
        else $error("stopped counter not zero");
    a_idle_no_irq: assert property (runs_q == 2'h0 && $past(runs_q) == 2'h0 |-> !chan0_match_irq && !chan1_match_irq)
        else $error("match request while both channels stopped");
    a_and_chan0_high: assert property (and_q && $past(and_q) |-> chan0_pwm_pin && chan0_pulse_gen_pin)
        else $error("channel 0 pins low with output AND");
    c_irq: cover property (chan0_match_irq);
    c_slverr: cover property (pready && pslverr);
    c_stop_run: cover property (stop_mode_entry && runs_q != 2'h0);
endmodule
bind dtc_timer_pair dtc_timer_pair_monitor dtc_timer_pair_monitor_i (.sys_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_mode_entry, .chan0_match_irq, .chan1_match_irq,
    .chan0_pwm_pin, .chan0_pulse_gen_pin);
`default_nettype wire

/* File: tb/dtc_timer_pair_tb.sv */
// Bench for the timer pair: register reset values, timer period, locks, stop entry, pin and slow sources.
// Assumes the APB slave answers after setup; low-frequency inputs move only in their own scenario.
`default_nettype none
module dtc_timer_pair_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rstn, psel, penable, pwrite, stop_mode_entry, pin1, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, irq0, irq1, pwm0, ppg0, pwm1, ppg1, lfclk, osc, lpm;
    int          fail_count, checks_done, n;
    dtc_timer_pair dtc_timer_pair_i (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .low_freq_clock(lfclk), .low_freq_osc_ok(osc), .low_power_mode(lpm),
        .stop_mode_entry, .chan0_count_input_pin(1'b1), .chan1_count_input_pin(pin1),
        .chan0_match_irq(irq0), .chan1_match_irq(irq1), .chan0_pwm_pin(pwm0),
        .chan0_pulse_gen_pin(ppg0), .chan1_pwm_pin(pwm1), .chan1_pulse_gen_pin(ppg1));
    task automatic finish_test;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Hold the request until pready is sampled high; no latency assumed
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this time step
        @(posedge sys_clk);
    endtask
    task automatic wait_irq0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (irq0 !== 1'b1 && n < 300);
        if (irq0 !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic t_reset_regs;
        logic [15:0] ra [5] = '{16'h3dd0, 16'h009c, 16'h00a4, 16'h00ac, 16'h00b0};
        logic [31:0] rv [5] = '{32'h0, 32'hff, 32'hff, 32'hc0, 32'h0};
        for (int i = 0; i < 5; i++) begin
            if (i == 1) begin
                apb(1'b1, 16'h3dd0, 32'h10);
            end
            apb(1'b0, ra[i], 32'h0);
            check(rd, rv[i]);
        end
        apb(1'b0, 16'h0004, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    task automatic t_gate_off;
        apb(1'b1, 16'h3dd0, 32'h10);
        apb(1'b1, 16'h00a8, 32'h38);
        apb(1'b1, 16'h0098, 32'h03);
        apb(1'b1, 16'h3dd0, 32'h00);
        apb(1'b1, 16'h00b0, 32'h01);
        repeat (20) @(posedge sys_clk);
        apb(1'b0, 16'h00c0, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 16'h00b0, 32'h00);
        apb(1'b1, 16'h3dd0, 32'h10);
    endtask
    task automatic t_timer_period;
        apb(1'b1, 16'h00b0, 32'h01);
        wait_irq0();
        wait_irq0();
        check(n, 32'h4);
        check({30'h0, pwm0, ppg0}, 32'h3);
        apb(1'b1, 16'h00b0, 32'h00);
        apb(1'b0, 16'h00c0, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic t_locks;
        apb(1'b1, 16'h00ac, 32'h38);
        apb(1'b1, 16'h00b0, 32'h02);
        apb(1'b1, 16'h00ac, 32'h00);
        apb(1'b0, 16'h00ac, 32'h0);
        check(rd, 32'h38);
        apb(1'b1, 16'h00b0, 32'h0e);
        apb(1'b0, 16'h00b0, 32'h0);
        check(rd, 32'h02);
        apb(1'b1, 16'h00b0, 32'h00);
        // Channel 0 as stopped PWM with low init level, so the AND result is low
        apb(1'b1, 16'h00a8, 32'h3a);
        apb(1'b1, 16'h00b0, 32'h0a);
        apb(1'b0, 16'h00b0, 32'h0);
        check(rd, 32'h0a);
        check({30'h0, pwm0, ppg0}, 32'h3);
        check({30'h0, pwm1, ppg1}, 32'h0);
        apb(1'b1, 16'h00b0, 32'h00);
    endtask
    task automatic t_stop;
        apb(1'b1, 16'h00b0, 32'h01);
        stop_mode_entry <= 1'b1;
        @(posedge sys_clk);
        stop_mode_entry <= 1'b0;
        apb(1'b0, 16'h00b0, 32'h0);
        check(rd, 32'h0);
    endtask
    // Internal code 111 would count every clock, so a count of 2 shows the pin drives it
    task automatic t_ext_pin;
        logic [31:0] hits;
        hits = 32'h0;
        apb(1'b1, 16'h00ac, 32'h3c);
        apb(1'b1, 16'h009c, 32'h03);
        apb(1'b1, 16'h00b0, 32'h02);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) begin
                apb(1'b0, 16'h00c4, 32'h0);
                check(rd, 32'h2);
            end
            pin1 <= 1'b0;
            repeat (4) begin
                @(posedge sys_clk);
                hits = hits + irq1;
            end
            pin1 <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
        check(hits, 32'h1);
        apb(1'b0, 16'h00c4, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 16'h00b0, 32'h00);
    endtask
    // Dead oscillator gives no tick; fs/4 gives one tick per four slow edges
    task automatic t_low_freq;
        lpm <= 1'b1;
        apb(1'b1, 16'h00a8, 32'h38);
        apb(1'b1, 16'h00b0, 32'h01);
        for (int k = 0; k < 16; k++) begin
            osc <= (k >= 8);
            lfclk <= 1'b1;
            repeat (2) @(posedge sys_clk);
            lfclk <= 1'b0;
            repeat (2) @(posedge sys_clk);
            if (k == 7) begin
                apb(1'b0, 16'h00c0, 32'h0);
                check(rd, 32'h0);
            end
        end
        apb(1'b0, 16'h00c0, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, 16'h00b0, 32'h00);
        lpm <= 1'b0;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        {rstn, psel, penable, pwrite, stop_mode_entry, paddr, pwdata, lfclk, lpm} = '0;
        pin1 = 1'b1;
        osc = 1'b1;
        fail_count = 0;
        checks_done = 0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_reset_regs();
        t_gate_off();
        t_timer_period();
        t_locks();
        t_stop();
        t_ext_pin();
        t_low_freq();
        finish_test();
    end
endmodule
`default_nettype wire
